// File: scwr_pkg.sv
// Package for the split-cycle write-restart bus controller
`default_nettype none
package scwr_pkg;

  localparam int unsigned DATA_W = 36;

  // Hold counter between acknowledge and restart pulse
  localparam int unsigned SCWR_CNT_W         = 8;
  localparam int unsigned SCWR_DELAY_MAX     = (1 << SCWR_CNT_W) - 1;
  // Restart as early as allowed; the memory latches a pulse that beats its read
  localparam int unsigned SCWR_DELAY_DEFAULT = 0;

  // User-side command toward the memory bus
  typedef struct packed {
    logic              rd;    // Read wanted (read-only or split)
    logic              wr;    // Write wanted (write-only or split)
    logic [DATA_W-1:0] wdata; // Data for the rewrite
  } scwr_cmd_type;

  // Pins driven toward the memory control
  typedef struct packed {
    logic              read_request_line;
    logic              write_request_line;
    logic              write_restart_pulse;
    logic [DATA_W-1:0] bus_data_lines;
  } scwr_bus_type;

  typedef enum logic [1:0] {
    SCWR_IDLE  = 2'b00,
    SCWR_WAIT  = 2'b01,
    SCWR_HOLD  = 2'b11,
    SCWR_DONE  = 2'b10
  } scwr_state_type;

endpackage : scwr_pkg
`default_nettype wire

// File: scwr_ctrl.sv
// Processor-side controller driving split, write-only and read-only memory cycles
//
// What this block and the memory do
// RL1: Send one write-restart pulse in every cycle with write request asserted.
// RL2: Memory waits for write-restart before rewriting; controller supplies it.
// RL3: Never send write-restart before address acknowledge has been received.
// RL4: Memory remembers early write-restart; controller may send it right at acknowledge.
// RL5: Memory halts after read portion until write-restart arrives.
// RL6: Memory resumes the write portion as soon as write-restart arrives.
// RL7: Drive write data on bus data lines together with write-restart pulse.
// RL8: Never send write-restart in a read-only cycle.
// RL9: Read-only cycle completes in memory without any write-restart.
`timescale 1ns/1ps
`default_nettype none
module scwr_ctrl #(
  parameter int unsigned RESTART_DELAY = scwr_pkg::SCWR_DELAY_DEFAULT  // Extra cycles after acknowledge before restart
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire scwr_pkg::scwr_cmd_type cmd,
  input  wire logic                   cmd_valid,
  output var  logic                   cmd_ready,
  input  wire logic                   address_acknowledge,
  output var  scwr_pkg::scwr_bus_type bus,
  output var  logic                   cycle_done
);
  import scwr_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // A delay beyond the hold counter would wrap and fire the restart early
  if (RESTART_DELAY > SCWR_DELAY_MAX) begin : g_bad_delay
    $error("RESTART_DELAY exceeds the hold counter range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  scwr_state_type          state_ff;
  scwr_state_type          nxt_state;
  // Command is held for the whole cycle so the word is stable until the pulse
  scwr_cmd_type            cmd_ff;
  scwr_cmd_type            nxt_cmd;
  logic [SCWR_CNT_W-1:0]   cnt_ff;
  logic [SCWR_CNT_W-1:0]   nxt_cnt;

  logic                    rdy_ff;
  logic                    nxt_rdy;
  logic                    done_ff;
  logic                    nxt_done;

  logic                    rd_line_ff;
  logic                    nxt_rd_line;
  logic                    wr_line_ff;
  logic                    nxt_wr_line;

  logic                    pulse_ff;
  logic                    nxt_pulse;
  logic [DATA_W-1:0]       data_ff;
  logic [DATA_W-1:0]       nxt_data;
  wire  [DATA_W-1:0]       gated_data;

  // ----------------------------------------
  // Decoded events
  // ----------------------------------------
  logic                    take;
  logic                    acked;
  logic                    fire;

  // A command with neither read nor write names no memory cycle and is ignored
  assign take  = (state_ff == SCWR_IDLE) && cmd_valid && rdy_ff && (cmd.rd || cmd.wr);
  // An acknowledge outside WAIT belongs to no cycle of ours and is dropped
  assign acked = (state_ff == SCWR_WAIT) && address_acknowledge;
  // The restart fires once the hold count has run out
  assign fire  = (state_ff == SCWR_HOLD) && (cnt_ff == '0);

  // Data lines carry the word only during the restart pulse
  for (genvar gi = 0; gi < DATA_W; gi++) begin : g_data_bit
    assign gated_data[gi] = fire & cmd_ff.wdata[gi];
  end

  // ----------------------------------------
  // Cycle sequencing
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd   = cmd_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      SCWR_IDLE: begin
        if (take) begin
          nxt_cmd   = cmd;
          nxt_state = SCWR_WAIT;
        end
      end
      SCWR_WAIT: begin
        // Restart may only follow the acknowledge
        if (acked) begin // RL3
          nxt_cnt = SCWR_CNT_W'(RESTART_DELAY);
          if (cmd_ff.wr) begin
            nxt_state = SCWR_HOLD; // RL1
          end else begin
            nxt_state = SCWR_DONE; // RL8
          end
        end
      end
      SCWR_HOLD: begin
        // Memory holds its chain until the pulse and latches an early one, so no wait is needed
        if (fire) begin
          nxt_state = SCWR_DONE;
        end else begin
          nxt_cnt = cnt_ff - SCWR_CNT_W'(1);
        end
      end
      SCWR_DONE: begin
        nxt_state = SCWR_IDLE;
      end
      default: begin
        nxt_state = SCWR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SCWR_IDLE;
      cmd_ff   <= '0;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff   <= nxt_cmd;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  always_comb begin
    nxt_rdy  = 1'b0;
    nxt_done = 1'b0;
    case (state_ff)
      SCWR_IDLE: begin
        // Ready rises one cycle into idle so a finished command is never taken twice
        nxt_rdy = !take;
      end
      SCWR_DONE: begin
        nxt_done = 1'b1;
      end
      default: begin
        nxt_rdy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdy_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      rdy_ff  <= nxt_rdy;
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------
  // Request lines
  // ----------------------------------------
  always_comb begin
    nxt_rd_line = rd_line_ff;
    nxt_wr_line = wr_line_ff;
    if (take) begin
      nxt_rd_line = cmd.rd;
      nxt_wr_line = cmd.wr;
    end else if (acked) begin
      // Dropped on the acknowledge so the memory never sees a second request
      nxt_rd_line = 1'b0;
      nxt_wr_line = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_line_ff <= 1'b0;
      wr_line_ff <= 1'b0;
    end else begin
      rd_line_ff <= nxt_rd_line;
      wr_line_ff <= nxt_wr_line;
    end
  end

  // ----------------------------------------
  // Restart pulse and write data
  // ----------------------------------------
  // Pulse and data share one register stage so they reach the pins together
  always_comb begin
    nxt_pulse = fire;       // RL1
    nxt_data  = gated_data; // RL7
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff <= 1'b0;
      data_ff  <= '0;
    end else begin
      pulse_ff <= nxt_pulse;
      data_ff  <= nxt_data;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Limitation: a reset in mid cycle leaves the memory mid-read; reset it together with this block
  assign cmd_ready  = rdy_ff;
  assign bus        = {rd_line_ff, wr_line_ff, pulse_ff, data_ff};
  assign cycle_done = done_ff;

endmodule // scwr_ctrl
`default_nettype wire

// File: scwr_chk.sv
// Port checker for the write-restart controller
`timescale 1ns/1ps
`default_nettype none
module scwr_chk import scwr_pkg::*; (
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire logic         address_acknowledge,
  input wire logic         cycle_done,
  input wire scwr_bus_type bus
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Set by an acknowledge, cleared at the end of the cycle it belongs to
  logic ack_seen_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_seen_ff <= 1'b0;
    end else if (address_acknowledge) begin
      ack_seen_ff <= 1'b1;
    end else if (cycle_done) begin
      ack_seen_ff <= 1'b0;
    end
  end
  property p_ord; bus.write_restart_pulse |-> ack_seen_ff; endproperty
  a_ord: assert property (p_ord) else $error("restart without ack in this cycle");
  property p_once; bus.write_restart_pulse |=> !bus.write_restart_pulse; endproperty
  a_once: assert property (p_once) else $error("restart pulse longer than one cycle");
  property p_ack; bus.write_restart_pulse |-> $past(address_acknowledge, 2); endproperty
  a_ack: assert property (p_ack) else $error("restart before ack");
  property p_wr; bus.write_request_line && address_acknowledge |-> ##2 bus.write_restart_pulse; endproperty
  a_wr: assert property (p_wr) else $error("no restart in write cycle");
  property p_rd; bus.read_request_line && !bus.write_request_line && address_acknowledge
    |-> ##1 !bus.write_restart_pulse ##1 (cycle_done && !bus.write_restart_pulse); endproperty
  a_rd: assert property (p_rd) else $error("restart in read-only cycle");
  property p_dat; !bus.write_restart_pulse |-> bus.bus_data_lines == '0; endproperty
  a_dat: assert property (p_dat) else $error("data outside restart");
endmodule // scwr_chk
`default_nettype wire

// File: scwr_mem.sv
// Behavioural memory control on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module scwr_mem import scwr_pkg::*; (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire scwr_bus_type      bus,
  input  wire logic [3:0]        ack_dly,
  input  wire logic [3:0]        rd_t,
  output var  logic              address_acknowledge,
  output var  logic [DATA_W-1:0] word_ff,
  output var  logic [7:0]        n_wr
);
  logic [3:0] cnt, rt;
  logic       wr_ff, rs_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {cnt, rt, address_acknowledge, rs_ff, wr_ff, n_wr, word_ff} <= '0;
    end else begin
      address_acknowledge <= 1'h0;
      // Busy memory holds off the next acknowledge
      if ((bus.read_request_line | bus.write_request_line) && rt == 4'h0 && !address_acknowledge) begin
        cnt <= (cnt == ack_dly) ? 4'h0 : cnt + 4'h1;
        if (cnt == ack_dly) begin
          {address_acknowledge, rt, wr_ff} <= {1'h1, rd_t, bus.write_request_line};
        end
      end
      if (bus.write_restart_pulse) begin
        {rs_ff, word_ff} <= {1'h1, bus.bus_data_lines};
      end
      if (rt > 4'h1) rt <= rt - 4'h1;
      else if (rt == 4'h1 && (!wr_ff || rs_ff || bus.write_restart_pulse)) begin
        {rt, rs_ff} <= '0;
        n_wr <= n_wr + {7'h0, wr_ff};
      end
    end
  end
endmodule // scwr_mem
`default_nettype wire

// File: tb_top.sv
// Testbench for the write-restart controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
  import scwr_pkg::*;
  typedef struct {logic rd, wr; logic [DATA_W-1:0] d; logic [3:0] a, t;} scwr_row_type;
  logic clk_sys = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, cmd_ready, address_acknowledge, cycle_done;
  logic [3:0] ack_dly = 4'h0, rd_t = 4'h1;
  logic [DATA_W-1:0] word, w;
  logic [7:0] n_wr, e;
  scwr_cmd_type cmd = '0;
  scwr_bus_type bus;
  int fail_count = 0, n_compared = 0, k;
  // Halted split, early write, read-only, slow ack write
  scwr_row_type rows[4] = '{'{1'h1, 1'h1, 36'h123456789, 4'h0, 4'h1}, '{1'h0, 1'h1, 36'hFEDCBA987, 4'h3, 4'h8},
    '{1'h1, 1'h0, 36'h0, 4'h1, 4'h2}, '{1'h0, 1'h1, 36'hA5A5A5A5A, 4'h7, 4'h9}};
  always #2 clk_sys = ~clk_sys;
  scwr_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .address_acknowledge(address_acknowledge), .bus(bus), .cycle_done(cycle_done));
  scwr_mem u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .ack_dly(ack_dly), .rd_t(rd_t),
    .address_acknowledge(address_acknowledge), .word_ff(word), .n_wr(n_wr));
  task summarize;
    $display("compared %0d errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task timed_out;
    fail_count++;
    $display("[ERR] wait exp done got timeout");
    summarize();
  endtask
  task run_cycle(input scwr_row_type r);
    {e, w} = {n_wr + {7'h0, r.wr}, r.wr ? r.d : word};
    {ack_dly, rd_t, cmd, cmd_valid} = {r.a, r.t, r.rd, r.wr, r.d, 1'h1};
    for (k = 0; k < 50 && cmd_ready !== 1'h1; k++) @(negedge clk_sys);
    if (k == 50) timed_out();
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    for (k = 0; k < 50 && cycle_done !== 1'h1; k++) @(negedge clk_sys);
    if (k == 50) timed_out();
    repeat (12) @(negedge clk_sys);
    `CHK("n_wr", e, n_wr)
    `CHK("word", w, word)
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    `CHK("bus_rst", 41'h0, {cmd_ready, bus, cycle_done})
    rst_n = 1'h1;
    foreach (rows[i]) run_cycle(rows[i]);
    {cmd, cmd_valid} = {38'h0, 1'h1};
    repeat (10) @(negedge clk_sys);
    `CHK("idle", 41'h10000000000, {cmd_ready, bus, cycle_done})
    // Reset while the request stands, before the acknowledge
    {cmd, cmd_valid} = {2'h3, 36'h5A5A5A5A5, 1'h1};
    for (k = 0; k < 50 && bus.write_request_line !== 1'h1; k++) @(negedge clk_sys);
    if (k == 50) timed_out();
    {rst_n, cmd_valid} = 2'h0;
    @(negedge clk_sys);
    `CHK("rst_mid", 41'h0, {cmd_ready, bus, cycle_done})
    rst_n = 1'h1;
    run_cycle('{1'h1, 1'h1, 36'h5A5A5A5A5, 4'h2, 4'h3});
    summarize();
  end
endmodule // tb_top
bind scwr_ctrl scwr_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .address_acknowledge(address_acknowledge),
  .cycle_done(cycle_done), .bus(bus));
`default_nettype wire
